// ### hrs_pkg.sv
// package: constants, register map and carrier types of the hart status block
package hrs_pkg;

  // ****************************************************************
  // ****************************************************************

  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned BUSY_TIME_MS     = 10_000;
  localparam int unsigned BUSY_CYC_DEF     = BUSY_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned TICK_TIME_MS     = 250;
  localparam int unsigned TICK_CYC_DEF     = TICK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned RSP_WAIT_CYC_DEF = 2000;
  localparam int unsigned GAP_CYC_DEF      = 1000;

  localparam int EB_TMO  = 0;
  localparam int EB_ZERO = 1;
  localparam int EB_GAP  = 2;
  localparam int EB_CSUM = 3;
  localparam int EB_FRM  = 4;
  localparam int EB_OVR  = 5;
  localparam int EB_PAR  = 6;
  localparam int EB_BUSY = 7;

  localparam logic [9:0] OFF_ERR0 = 10'h000;
  localparam logic [9:0] OFF_ERR1 = 10'h004;
  localparam logic [9:0] OFF_CFG0 = 10'h008;
  localparam logic [9:0] OFF_CFG1 = 10'h00c;
  localparam logic [9:0] OFF_DETS = 10'h010;
  localparam logic [9:0] OFF_DEF  = 10'h014;
  localparam logic [9:0] OFF_RDY  = 10'h018;
  localparam logic [9:0] OFF_PV0  = 10'h01c;
  localparam logic [9:0] OFF_PV1  = 10'h020;
  localparam logic [9:0] OFF_CUR  = 10'h024;
  localparam logic [9:0] OFF_TAG0 = 10'h100;
  localparam logic [9:0] OFF_TAG1 = 10'h200;
  localparam logic [6:0] TAG_LEN  = 7'h26;

  localparam int CF_RTRY_LSB = 0;
  localparam int CF_FILT_LSB = 8;
  localparam int CF_UPD_LSB  = 16;
  localparam int CS_LSB      = 8;
  localparam int RC_LSB      = 16;

  localparam logic [6:0] RTRY_DEF = 7'h03;
  localparam logic [4:0] FILT_DEF = 5'h03;
  localparam logic [4:0] FILT_MAX = 5'h14;
  localparam logic [7:0] UPD_DEF  = 8'h0c;

  typedef struct packed {
    logic [7:0] upd;
    logic [4:0] filt;
    logic [6:0] rtry;
  } hrs_cfg_type;

  localparam hrs_cfg_type CFG_DEF = '{upd: UPD_DEF, filt: FILT_DEF, rtry: RTRY_DEF};

  typedef struct packed {
    logic       valid;
    logic       eof;
    logic       fe;
    logic       oe;
    logic       pe;
    logic [7:0] data;
  } hrs_rx_type;

  typedef struct packed {
    logic       wr;
    logic       ch;
    logic [5:0] idx;
    logic [7:0] data;
    logic       done;
    logic [1:0] found;
  } hrs_det_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_WAIT = 2'b01,
    RX_RECV = 2'b10
  } hrs_rxst_type;

  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_OK    = 2'b01,
    CS_PERR  = 2'b10,
    CS_NOACC = 2'b11
  } hrs_comm_type;

  typedef struct packed {
    hrs_rxst_type st;
    logic [31:0]  tmr;
    logic [31:0]  bsy;
    logic [7:0]   acc;
    logic [7:0]   ferr;
    logic [7:0]   err;
    logic         done;
    logic         ok;
  } hrs_chst_type;

endpackage

// ### hrs_chan.sv
// per-channel protocol error tracking of one hart response
`timescale 1ns/10ps
module hrs_chan #(
  parameter int unsigned RSP_WAIT_CYC = hrs_pkg::RSP_WAIT_CYC_DEF,
  parameter int unsigned GAP_CYC      = hrs_pkg::GAP_CYC_DEF,
  parameter int unsigned BUSY_CYC     = hrs_pkg::BUSY_CYC_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                cmd_go_i,
  input  wire logic                link_busy_i,
  input  wire hrs_pkg::hrs_rx_type rx_i,
  input  wire logic [7:0]          clr_i,
  output logic      [7:0]          err_o,
  output logic                     done_o,
  output logic                     ok_o
);
  import hrs_pkg::*;

  hrs_chst_type state_r;
  hrs_chst_type state_nxt;

  // ****************************************************************
  // frame tracking
  // ****************************************************************
  always_comb begin
    logic [7:0] fv;
    logic       fin;
    fv             = state_r.ferr;
    fin            = 1'b0;
    state_nxt      = state_r;
    state_nxt.done = 1'b0;
    if (link_busy_i) begin
      if (state_r.bsy != 32'(BUSY_CYC)) begin
        state_nxt.bsy = state_r.bsy + 32'h1;
      end
    end else begin
      state_nxt.bsy = '0;
    end
    case (state_r.st)
      RX_IDLE: begin
        if (cmd_go_i) begin
          state_nxt.st  = RX_WAIT;
          state_nxt.tmr = '0;
          state_nxt.acc = 8'h00;
          fv            = 8'h00;
        end
      end
      RX_WAIT, RX_RECV: begin
        if (rx_i.valid) begin
          state_nxt.st  = RX_RECV;
          state_nxt.tmr = '0;
          state_nxt.acc = state_r.acc ^ rx_i.data;
          fv[EB_FRM]    = fv[EB_FRM] | rx_i.fe;
          fv[EB_OVR]    = fv[EB_OVR] | rx_i.oe;
          fv[EB_PAR]    = fv[EB_PAR] | rx_i.pe;
          if (rx_i.eof) begin
            fv[EB_CSUM] = fv[EB_CSUM] | ((state_r.acc ^ rx_i.data) != 8'h00);
            fin         = 1'b1;
          end
        end else if (state_r.st == RX_WAIT && state_r.tmr == 32'(RSP_WAIT_CYC - 1)) begin
          fv[EB_TMO] = 1'b1;
          fin        = 1'b1;
        end else if (state_r.st == RX_RECV && state_r.tmr == 32'(GAP_CYC - 1)) begin
          fv[EB_GAP] = 1'b1;
          fin        = 1'b1;
        end else begin
          state_nxt.tmr = state_r.tmr + 32'h1;
        end
      end
      default: begin
        state_nxt.st = RX_IDLE;
      end
    endcase
    state_nxt.ferr = fv;
    if (fin) begin
      state_nxt.st   = RX_IDLE;
      state_nxt.done = 1'b1;
      state_nxt.ok   = (fv == 8'h00);
    end
    // set wins over software clear
    state_nxt.err = (state_r.err & ~clr_i) | (fin ? fv : 8'h00);
    if (link_busy_i && state_r.bsy == 32'(BUSY_CYC)) begin
      state_nxt.err[EB_BUSY] = 1'b1;
    end
    state_nxt.err[EB_ZERO] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign err_o  = state_r.err;
  assign done_o = state_r.done;
  assign ok_o   = state_r.ok;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_bit_one_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    err_o[EB_ZERO] == 1'b0) else $error("error bit 1 not zero");
  a_wait_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.st == RX_WAIT && !rx_i.valid && state_r.tmr == 32'(RSP_WAIT_CYC - 1))
    |=> (err_o[EB_TMO] && done_o && !ok_o)) else $error("wait expiry not flagged");
  a_gap_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.st == RX_RECV && !rx_i.valid && state_r.tmr == 32'(GAP_CYC - 1))
    |=> (err_o[EB_GAP] && state_r.st == RX_IDLE)) else $error("byte gap not flagged");
  a_csum_check: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.st != RX_IDLE && rx_i.valid && rx_i.eof && (state_r.acc ^ rx_i.data) != 8'h00)
    |=> ##0 err_o[EB_CSUM] ##1 err_o[EB_CSUM] || $past(clr_i[EB_CSUM]))
    else $error("checksum error not flagged");
  a_uart_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.st != RX_IDLE && rx_i.valid && rx_i.eof)
    |=> ((err_o[EB_PAR:EB_FRM] & $past({rx_i.pe, rx_i.oe, rx_i.fe}))
         == $past({rx_i.pe, rx_i.oe, rx_i.fe}))) else $error("receiver error lost");
  a_busy_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (link_busy_i && state_r.bsy == 32'(BUSY_CYC)) |=> err_o[EB_BUSY])
    else $error("occupied link not flagged");

endmodule // hrs_chan

// ### hrs_top.sv
// hart status, diagnostic records and additional parameters of a two-channel module
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module hrs_top #(
  parameter int unsigned RSP_WAIT_CYC = hrs_pkg::RSP_WAIT_CYC_DEF,
  parameter int unsigned GAP_CYC      = hrs_pkg::GAP_CYC_DEF,
  parameter int unsigned BUSY_CYC     = hrs_pkg::BUSY_CYC_DEF,
  parameter int unsigned TICK_CYC     = hrs_pkg::TICK_CYC_DEF
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  input  wire logic                      we_i,
  input  wire logic [9:2]                adr_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  output logic                           ack_o,
  input  wire hrs_pkg::hrs_rx_type [1:0] rx_i,
  input  wire logic [1:0]                link_busy_i,
  input  wire logic [1:0]                port_busy_i,
  input  wire logic [1:0]                cmd_req_i,
  output logic      [1:0]                cmd_rdy_o,
  output logic      [1:0]                cmd_go_o,
  output logic      [1:0]                cmd_auto_o,
  input  wire logic [1:0]                wire_open_i,
  output logic      [1:0]                wire_break_o,
  input  wire logic [1:0][15:0]          cur_i,
  input  wire logic [1:0][31:0]          pv_i,
  input  wire logic [13:0]               resp_new_i,
  input  wire hrs_pkg::hrs_det_type      det_i,
  output logic                           scan_o,
  output logic                           parmd_o
);
  import hrs_pkg::*;

  typedef struct packed {
    hrs_cfg_type  [1:0]      cfg;
    logic                    parmd;
    logic                    boot;
    logic                    scan;
    logic                    det_done;
    logic         [1:0]      found;
    logic         [13:0]     rdy;
    logic         [31:0]     tick;
    logic         [1:0][4:0] wbc;
    logic         [1:0]      wbf;
    logic         [1:0][7:0] updc;
    logic         [1:0]      pend;
    logic         [1:0]      auto;
    logic         [1:0]      arm;
    logic         [1:0][6:0] rcnt;
    logic         [1:0]      go;
    logic         [1:0]      goa;
    hrs_comm_type [1:0]      comm;
    logic                    ack;
    logic         [31:0]     dat;
  } hrs_top_type;

  hrs_top_type       state_r;
  hrs_top_type       state_nxt;
  logic [7:0]        tag_mem [0:2*TAG_LEN-1];
  logic [6:0]        tag_widx;
  logic              tk;
  logic              req;
  logic              wr;
  logic [9:0]        off;
  logic [31:0]       wmask;
  logic [1:0][7:0]   ch_clr;
  logic [1:0][7:0]   ch_err;
  logic [1:0]        ch_done;
  logic [1:0]        ch_ok;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign off   = {adr_i, 2'b00};
  assign req   = cyc_i & stb_i;
  assign wr    = req & we_i & state_r.ack;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign tk    = (state_r.tick == 32'(TICK_CYC - 1));

  assign ch_clr[0] = (wr && off == OFF_ERR0) ? (dat_i[7:0] & wmask[7:0]) : 8'h00;
  assign ch_clr[1] = (wr && off == OFF_ERR1) ? (dat_i[7:0] & wmask[7:0]) : 8'h00;

  // ****************************************************************
  // per-channel response checking
  // ****************************************************************
  generate
    for (genvar g = 0; g < 2; g++) begin : g_chan
      hrs_chan #(
        .RSP_WAIT_CYC (RSP_WAIT_CYC),
        .GAP_CYC      (GAP_CYC),
        .BUSY_CYC     (BUSY_CYC)
      ) u_chan (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .cmd_go_i     (state_r.go[g]),
        .link_busy_i  (link_busy_i[g]),
        .rx_i         (rx_i[g]),
        .clr_i        (ch_clr[g]),
        .err_o        (ch_err[g]),
        .done_o       (ch_done[g]),
        .ok_o         (ch_ok[g])
      );
    end
  endgenerate

  // ****************************************************************
  // detected device tags
  // ****************************************************************
  assign tag_widx = det_i.ch ? (TAG_LEN + {1'b0, det_i.idx}) : {1'b0, det_i.idx};

  always_ff @(posedge clk_i) begin
    if (det_i.wr && {1'b0, det_i.idx} < TAG_LEN) begin
      tag_mem[tag_widx] <= det_i.data;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0]  rd;
    logic [31:0]  v;
    logic [31:0]  cw;
    logic [6:0]   ridx;
    hrs_cfg_type  cv;
    rd                = 32'h0000_0000;
    v                 = 32'h0000_0000;
    cw                = 32'h0000_0000;
    ridx              = 7'h00;
    cv                = CFG_DEF;
    state_nxt         = state_r;
    state_nxt.scan    = 1'b0;
    state_nxt.go      = 2'b00;
    state_nxt.goa     = 2'b00;
    state_nxt.tick    = tk ? 32'h0000_0000 : state_r.tick + 32'h1;

    // startup detection request
    if (state_r.boot) begin
      state_nxt.boot = 1'b0;
      state_nxt.scan = 1'b1;
    end
    if (det_i.done) begin
      state_nxt.det_done = 1'b1;
      state_nxt.found    = det_i.found;
    end

    for (int c = 0; c < 2; c++) begin
      // wire break filter in quarter seconds
      if (!wire_open_i[c]) begin
        state_nxt.wbc[c] = 5'h00;
        state_nxt.wbf[c] = 1'b0;
      end else if (state_r.cfg[c].filt == 5'h00) begin
        state_nxt.wbf[c] = 1'b1;
      end else if (tk && !state_r.wbf[c]) begin
        if (state_r.wbc[c] == state_r.cfg[c].filt) begin
          state_nxt.wbf[c] = 1'b1;
        end else begin
          state_nxt.wbc[c] = state_r.wbc[c] + 5'h01;
        end
      end

      // command attempt with retries on a busy port
      if (state_r.pend[c] && (state_r.arm[c] || tk)) begin
        state_nxt.arm[c] = 1'b0;
        if (!port_busy_i[c]) begin
          state_nxt.pend[c] = 1'b0;
          state_nxt.go[c]   = 1'b1;
          state_nxt.goa[c]  = state_r.auto[c];
        end else if (state_r.rcnt[c] == state_r.cfg[c].rtry) begin
          state_nxt.pend[c] = 1'b0;
          state_nxt.comm[c] = CS_NOACC;
        end else begin
          state_nxt.rcnt[c] = state_r.rcnt[c] + 7'h01;
        end
      end

      // host command request
      if (cmd_req_i[c] && !state_r.pend[c]) begin
        state_nxt.pend[c] = 1'b1;
        state_nxt.auto[c] = 1'b0;
        state_nxt.arm[c]  = 1'b1;
        state_nxt.rcnt[c] = 7'h00;
      end

      // cyclic primary variable read
      if (state_r.cfg[c].upd == 8'h00) begin
        state_nxt.updc[c] = 8'h00;
      end else if (tk) begin
        if (state_r.updc[c] + 8'h01 >= state_r.cfg[c].upd) begin
          state_nxt.updc[c] = 8'h00;
          if (!state_r.pend[c] && !cmd_req_i[c]) begin
            state_nxt.pend[c] = 1'b1;
            state_nxt.auto[c] = 1'b1;
            state_nxt.arm[c]  = 1'b1;
            state_nxt.rcnt[c] = 7'h00;
          end
        end else begin
          state_nxt.updc[c] = state_r.updc[c] + 8'h01;
        end
      end

      // communication state after the last command
      if (ch_done[c]) begin
        state_nxt.comm[c] = ch_ok[c] ? CS_OK : CS_PERR;
      end

      // additional parameter record of this channel only
      cw = {8'h00, state_r.cfg[c].upd, 3'h0, state_r.cfg[c].filt, 1'b0, state_r.cfg[c].rtry};
      if (wr && off == ((c == 0) ? OFF_CFG0 : OFF_CFG1)) begin
        v       = (cw & ~wmask) | (dat_i & wmask);
        cv.rtry = v[CF_RTRY_LSB +: 7];
        cv.filt = v[CF_FILT_LSB +: 5];
        cv.upd  = v[CF_UPD_LSB +: 8];
        if (cv.filt <= FILT_MAX) begin
          state_nxt.cfg[c] = cv;
          state_nxt.parmd  = 1'b1;
        end
      end
    end

    // default parameters only while unparameterized
    if (wr && off == OFF_DEF && sel_i[0] && dat_i[7:0] != 8'h00 && !state_r.parmd) begin
      state_nxt.cfg   = {CFG_DEF, CFG_DEF};
      state_nxt.parmd = 1'b1;
    end

    // data ready flags, set wins over clear
    if (wr && off == OFF_RDY) begin
      state_nxt.rdy = state_r.rdy & ~(dat_i[13:0] & wmask[13:0]);
    end
    state_nxt.rdy = state_nxt.rdy | resp_new_i;

    // read data
    case (off)
      OFF_ERR0: begin
        rd = {9'h000, state_r.rcnt[0], 6'h00, state_r.comm[0], ch_err[0]};
      end
      OFF_ERR1: begin
        rd = {9'h000, state_r.rcnt[1], 6'h00, state_r.comm[1], ch_err[1]};
      end
      OFF_CFG0: begin
        rd = {8'h00, state_r.cfg[0].upd, 3'h0, state_r.cfg[0].filt, 1'b0, state_r.cfg[0].rtry};
      end
      OFF_CFG1: begin
        rd = {8'h00, state_r.cfg[1].upd, 3'h0, state_r.cfg[1].filt, 1'b0, state_r.cfg[1].rtry};
      end
      OFF_DETS: begin
        rd = {tag_mem[TAG_LEN], tag_mem[0], 13'h0000, state_r.det_done, state_r.found};
      end
      OFF_DEF: begin
        rd = {31'h0000_0000, state_r.parmd};
      end
      OFF_RDY: begin
        rd = {18'h00000, state_r.rdy};
      end
      OFF_PV0: begin
        rd = pv_i[0];
      end
      OFF_PV1: begin
        rd = pv_i[1];
      end
      OFF_CUR: begin
        rd = {cur_i[1], cur_i[0]};
      end
      default: begin
        if ({1'b0, adr_i[7:2]} < TAG_LEN && off[9:8] == OFF_TAG0[9:8]) begin
          rd = {24'h000000, tag_mem[{1'b0, adr_i[7:2]}]};
        end else if ({1'b0, adr_i[7:2]} < TAG_LEN && off[9:8] == OFF_TAG1[9:8]) begin
          ridx = TAG_LEN + {1'b0, adr_i[7:2]};
          rd   = {24'h000000, tag_mem[ridx]};
        end
      end
    endcase

    state_nxt.ack = req & ~state_r.ack;
    if (req && !state_r.ack) begin
      state_nxt.dat = rd;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= '0;
      state_r.cfg  <= {CFG_DEF, CFG_DEF};
      state_r.boot <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign dat_o        = state_r.dat;
  assign ack_o        = state_r.ack;
  assign cmd_rdy_o    = ~state_r.pend;
  assign cmd_go_o     = state_r.go;
  assign cmd_auto_o   = state_r.goa;
  assign wire_break_o = state_r.wbf;
  assign scan_o       = state_r.scan;
  assign parmd_o      = state_r.parmd;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held longer than one cycle");

  a_chan_own_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && off == OFF_CFG0) |=> (state_r.cfg[1] == $past(state_r.cfg[1])))
    else $error("channel 0 record changed channel 1");

  a_retry_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.pend[0] && (state_r.arm[0] || tk) && port_busy_i[0]
     && state_r.rcnt[0] == state_r.cfg[0].rtry)
    |=> (!state_r.pend[0] && state_r.comm[0] == CS_NOACC && !cmd_go_o[0]))
    else $error("retry limit not honoured");

  a_filt_range: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r.cfg[0].filt <= FILT_MAX && state_r.cfg[1].filt <= FILT_MAX)
    else $error("filter time out of range");

  a_filt_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.cfg[0].filt == 5'h00 && wire_open_i[0]) |=> wire_break_o[0])
    else $error("zero filter did not pass wire break");

  a_filt_off_ch1: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.cfg[1].filt == 5'h00 && wire_open_i[1]) |=> wire_break_o[1])
    else $error("zero filter did not pass wire break on channel 1");

  a_upd_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r.cfg[0].upd == 8'h00 && !state_r.pend[0] && !cmd_req_i[0])
    |=> !state_r.pend[0]) else $error("update ran while disabled");

  a_def_unparam: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && off == OFF_DEF && state_r.parmd) |=> $stable(state_r.cfg))
    else $error("defaults taken while parameterized");

  a_rdy_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (resp_new_i != 14'h0000) |=> ((state_r.rdy & $past(resp_new_i)) == $past(resp_new_i)))
    else $error("data ready bit not set");

endmodule // hrs_top

// ### hrs_fdev.sv
// field device model answering each command with a short frame in every mode but 2
`timescale 1ns/10ps
module hrs_fdev (
  input  wire logic           clk_i,
  input  wire logic           go_i,
  input  wire logic [2:0]     mode_i,
  output hrs_pkg::hrs_rx_type rx_o
);
  import hrs_pkg::*;
  logic [7:0] b [3];
  initial begin
    rx_o = '0;
    forever begin
      @(posedge clk_i);
      // mode 0 good, 1 bad checksum, 2 silent, 3 parity error, 4 stops after one byte
      if (go_i === 1'b1 && mode_i != 3'h2) begin
        b = '{8'h5a, 8'h81, 8'hdb ^ {7'h0, mode_i == 3'h1}};
        for (int k = 0; k < ((mode_i == 3'h4) ? 1 : 3); k++) begin
          repeat (3) @(posedge clk_i);
          rx_o <= '{1'b1, k == 2, 1'b0, 1'b0, mode_i == 3'h3 && k == 1, b[k]};
          @(posedge clk_i);
          rx_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~b[k]};
        end
      end
    end
  end
endmodule // hrs_fdev

// ### tb_hrs_top.sv
// testbench of the hart status block
`timescale 1ns/10ps
module tb_hrs_top;
  import hrs_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, scan_o, parmd_o;
  logic [9:2] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q, lfsr = 32'h86c0;
  hrs_rx_type [1:0] rx_i;
  hrs_rx_type rx0, rx1;
  hrs_det_type det_i;
  logic [1:0] link_busy_i, port_busy_i, cmd_req_i, cmd_rdy_o, cmd_go_o, cmd_auto_o;
  logic [1:0] wire_open_i, wire_break_o;
  logic [2:0] md;
  logic [1:0][15:0] cur_i;
  logic [1:0][31:0] pv_i;
  logic [13:0] resp_new_i;
  logic [31:0] ex [5] = '{32'h100, 32'h208, 32'h201, 32'h240, 32'h204};
  int errors = 0, checked = 0, cyc_n = 0;
  hrs_top #(.RSP_WAIT_CYC(40), .GAP_CYC(10), .BUSY_CYC(50), .TICK_CYC(20)) i_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rx_i,
    .link_busy_i, .port_busy_i, .cmd_req_i, .cmd_rdy_o, .cmd_go_o, .cmd_auto_o,
    .wire_open_i, .wire_break_o, .cur_i, .pv_i, .resp_new_i, .det_i, .scan_o, .parmd_o);
  hrs_fdev i_dev (.clk_i, .go_i(cmd_go_o[0]), .mode_i(md), .rx_o(rx0));
  assign rx_i = {rx1, rx0};
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a[9:2], d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 6000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, md, cmd_req_i, wire_open_i} = '0;
    {link_busy_i, port_busy_i, resp_new_i, rx1, det_i, cur_i, pv_i} = '0;
    sel_i = 4'hf;
    rst_i = 1'b1;
    cyc(8);
    rst_i <= 1'b0;
    cyc(2);
    chk(scan_o, 1);
    chk(cmd_rdy_o, 2'b11);
    bus(1, OFF_DEF, 0);
    cyc(1);
    chk(parmd_o, 0);
    bus(1, OFF_DEF, 1);
    cyc(1);
    chk(parmd_o, 1);
    bus(0, OFF_CFG0, 0);
    chk(q, 32'h000c0303);
    bus(0, 10'h3fc, 0);
    chk(q, 0);
    for (int i = 0; i < 300 && cmd_auto_o[0] !== 1'b1; i++) cyc(1);
    chk(cmd_auto_o[0], 1);
    bus(1, OFF_CFG0, 32'h303);
    bus(1, OFF_CFG0, 32'h1503);
    bus(1, OFF_DEF, 1);
    bus(0, OFF_CFG0, 0);
    chk(q, 32'h303);
    cyc(40);
    for (int m = 0; m < 5; m++) begin
      md <= m[2:0];
      cmd_req_i <= 2'b01;
      cyc(1);
      cmd_req_i <= 2'b00;
      cyc(70);
      bus(0, OFF_ERR0, 0);
      chk(q & 32'h7f03ff, ex[m]);
      bus(1, OFF_ERR0, 32'hff);
      bus(0, OFF_ERR0, 0);
      chk(q[7:0], 0);
    end
    port_busy_i <= 2'b01;
    cmd_req_i <= 2'b01;
    cyc(1);
    cmd_req_i <= 2'b00;
    cyc(1);
    chk(cmd_rdy_o, 2'b10);
    cyc(100);
    bus(0, OFF_ERR0, 0);
    chk(q & 32'h7f0300, 32'h30300);
    port_busy_i <= 2'b00;
    det_i <= '{1'b1, 1'b0, 6'h00, 8'ha5, 1'b0, 2'b00};
    cyc(1);
    det_i <= '{1'b1, 1'b1, 6'h00, 8'h3c, 1'b0, 2'b00};
    cyc(1);
    det_i <= '{1'b1, 1'b1, 6'h25, 8'h77, 1'b1, 2'b11};
    cyc(1);
    det_i <= '0;
    bus(0, OFF_DETS, 0);
    chk(q, 32'h3ca50007);
    bus(0, OFF_TAG1 + 10'h094, 0);
    chk(q, 32'h77);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      resp_new_i <= 14'h1 << (lfsr % 14);
      pv_i[0] <= lfsr;
      cur_i <= lfsr;
      cyc(1);
      resp_new_i <= '0;
      bus(0, OFF_RDY, 0);
      chk(q, 32'h1 << (lfsr % 14));
      bus(1, OFF_RDY, 32'h3fff);
      bus(0, OFF_PV0, 0);
      chk(q, lfsr);
    end
    bus(0, OFF_CUR, 0);
    chk(q, lfsr);
    link_busy_i <= 2'b01;
    cyc(60);
    link_busy_i <= 2'b00;
    bus(0, OFF_ERR0, 0);
    chk(q[7:0], 8'h80);
    bus(1, OFF_CFG1, 32'h3);
    wire_open_i <= 2'b11;
    cyc(3);
    chk(wire_break_o, 2'b10);
    cyc(100);
    chk(wire_break_o, 2'b11);
    summarize();
  end
endmodule // tb_hrs_top
